// ==== otp_prot_regs.v ====
// protection register unit: command decode, lock check, one-way programming
// assumes flash bus pins from outside the clock domain, host holds them steady
//
// Overview of operation
// - seventeen protection registers; the first has one lock per half, the others one lock each
// - first register is 128 bits; lower 64 bits hold factory device number
// - upper half of first register and sixteen more registers come blank
// - programmed bits never erase; unlocked registers take repeated programs
// - a programmed lock bit keeps reads but refuses all programming
// - lock bits are one-way too, so no register ever unlocks
// - read-identifier command at any address, then reads at register offset
// - reads return one 16-bit word per access
// - user areas are programmed one 16-bit word per operation
// - program command outside the protection space sets program error
// - programming a locked register sets program and lock error, no change
// - the same program command and data word program bits of a lock word
// - lock words sit at offsets 0x80 and 0x89
// - lock word a bit 0 comes programmed, locking the factory half
// - each bit of lock word b locks one of the sixteen upper registers
`timescale 1ns/100ps
`include "otp_consts.vh"

module otp_prot_regs #(
   parameter ADDR_W = 16,
   parameter DEPTH = 256,
   // factory device number, value arbitrary
   parameter [63:0] FACTORY_ID = 64'h0123456789ABCDEF
) (
   // clock and reset
   input wire clock,
   input wire rstn,
   // flash bus control pins
   input wire ce_n,
   input wire we_n,
   input wire oe_n,
   // flash bus address and data
   input wire [ADDR_W-1:0] addr,
   input wire [15:0] dq_in,
   output wire [15:0] dq_out,
   output wire dq_oe_n
);

// ==========================================================
// local codes
localparam IN_W = ADDR_W + 19;
localparam MODE_ARRAY = 2'b00;
localparam MODE_ID = 2'b01;
localparam MODE_STATUS = 2'b10;
localparam ST_IDLE = 3'b000;
localparam ST_SETUP = 3'b001;
localparam ST_LOCK = 3'b010;
localparam ST_CHECK = 3'b011;
localparam ST_MERGE = 3'b100;

// ==========================================================
// pin synchronisers
wire [IN_W-1:0] pin_bus;
reg [IN_W-1:0] sync1_r;
reg [IN_W-1:0] sync2_r;
reg we_d_r;

assign pin_bus = {ce_n, we_n, oe_n, addr, dq_in};

// two stages, second stage only read by logic
always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      sync1_r <= {IN_W{1'b1}};
      sync2_r <= {IN_W{1'b1}};
      we_d_r <= 1'b1;
   end
   else
   begin
      sync1_r <= pin_bus;
      sync2_r <= sync1_r;
      we_d_r <= sync2_r[IN_W-2];
   end
end

// ==========================================================
// decoded bus view
wire ce_s_n;
wire we_s_n;
wire oe_s_n;
wire [ADDR_W-1:0] addr_s;
wire [15:0] dq_s;
wire [`OTP_OFS_W-1:0] ofs;
wire [`OTP_OFS_W-1:0] ofs_rel;
wire [`OTP_IDX_W-1:0] bus_idx;
wire in_space;
wire wr_pulse;

assign ce_s_n = sync2_r[IN_W-1];
assign we_s_n = sync2_r[IN_W-2];
assign oe_s_n = sync2_r[IN_W-3];
assign addr_s = sync2_r[ADDR_W+15:16];
assign dq_s = sync2_r[15:0];
// upper address ignored
// only the low offset bits select a word, so raised upper bits do no harm
assign ofs = addr_s[`OTP_OFS_W-1:0];
assign ofs_rel = ofs - `OTP_SPACE_FIRST;
assign bus_idx = ofs_rel[`OTP_IDX_W-1:0];
// lock word offsets
// space starts at lock word a, lock word b sits inside it
assign in_space = (ofs >= `OTP_SPACE_FIRST) && (ofs <= `OTP_SPACE_LAST);
// write taken on rising write strobe while selected
assign wr_pulse = ~ce_s_n & we_s_n & ~we_d_r;

// ==========================================================
// control state
reg [1:0] mode_r;
reg [1:0] mode_nxt;
reg [2:0] state_r;
reg [2:0] state_nxt;
reg [`OTP_IDX_W-1:0] tgt_idx_r;
reg [`OTP_IDX_W-1:0] tgt_idx_nxt;
reg [15:0] pdata_r;
reg [15:0] pdata_nxt;
reg perr_r;
reg perr_nxt;
reg lerr_r;
reg lerr_nxt;
reg hit_d_r;
reg cmd_bad_r;
reg cmd_bad_nxt;

// storage port signals
reg [`OTP_IDX_W-1:0] mem_raddr;
wire [15:0] mem_rdata;
reg mem_we;
reg [15:0] mem_wdata;
reg perr_set;
reg lerr_set;
reg stat_clr;

// ==========================================================
// lock lookup for the held target
wire [`OTP_IDX_W-1:0] lock_idx;
wire [`OTP_IDX_W-1:0] blk_rel;
wire [3:0] blk_num;
reg tgt_locked;

assign lock_idx = (tgt_idx_r < `OTP_IDX_LOCK_B) ? `OTP_IDX_LOCK_A : `OTP_IDX_LOCK_B;
assign blk_rel = tgt_idx_r - `OTP_IDX_BLK_FIRST;
assign blk_num = blk_rel[`OTP_WORDS_PER_BLK_LOG2+3:`OTP_WORDS_PER_BLK_LOG2];

// lock word is on the read port while in check state
always @*
begin
   tgt_locked = 1'b0;
   if ((tgt_idx_r == `OTP_IDX_LOCK_A) || (tgt_idx_r == `OTP_IDX_LOCK_B))
      tgt_locked = 1'b0;
   else if (tgt_idx_r <= `OTP_IDX_FACT_LAST)
      tgt_locked = ~mem_rdata[`OTP_LOCK_A_FACT_BIT];
   else if (tgt_idx_r <= `OTP_IDX_USER0_LAST)
      tgt_locked = ~mem_rdata[`OTP_LOCK_A_USER_BIT];
   else
      tgt_locked = ~mem_rdata[blk_num];
end

// ==========================================================
// command decode and programming sequence
always @*
begin
   mode_nxt = mode_r;
   state_nxt = state_r;
   tgt_idx_nxt = tgt_idx_r;
   pdata_nxt = pdata_r;
   cmd_bad_nxt = cmd_bad_r;
   perr_set = 1'b0;
   lerr_set = 1'b0;
   stat_clr = 1'b0;
   mem_we = 1'b0;
   mem_wdata = mem_rdata & pdata_r;
   mem_raddr = bus_idx;
   case (state_r)
      ST_IDLE:
      begin
         if (wr_pulse)
         begin
            case (dq_s[7:0])
               `OTP_CMD_READ_ID: mode_nxt = MODE_ID;
               `OTP_CMD_READ_ARRAY: mode_nxt = MODE_ARRAY;
               `OTP_CMD_READ_STATUS: mode_nxt = MODE_STATUS;
               `OTP_CMD_CLEAR_STATUS: stat_clr = 1'b1;
               `OTP_CMD_PROG_PROT:
               begin
                  mode_nxt = MODE_STATUS;
                  state_nxt = ST_SETUP;
                  cmd_bad_nxt = ~in_space;
               end
               default: mode_nxt = mode_r;
            endcase
         end
      end
      ST_SETUP:
      begin
         if (wr_pulse)
         begin
            tgt_idx_nxt = bus_idx;
            pdata_nxt = dq_s;
            if (!in_space || cmd_bad_r)
            begin
               perr_set = 1'b1;
               state_nxt = ST_IDLE;
            end
            else
               state_nxt = ST_LOCK;
         end
      end
      ST_LOCK:
      begin
         mem_raddr = lock_idx;
         state_nxt = ST_CHECK;
      end
      ST_CHECK:
      begin
         mem_raddr = tgt_idx_r;
         if (tgt_locked)
         begin
            perr_set = 1'b1;
            lerr_set = 1'b1;
            state_nxt = ST_IDLE;
         end
         else
            state_nxt = ST_MERGE;
      end
      ST_MERGE:
      begin
         mem_raddr = tgt_idx_r;
         // lock words merged the same way
         mem_we = 1'b1;
         state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
   endcase
   // status flags, a set beats a clear
   perr_nxt = (perr_r & ~stat_clr) | perr_set;
   lerr_nxt = (lerr_r & ~stat_clr) | lerr_set;
end

// state registers
always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      mode_r <= MODE_ARRAY;
      state_r <= ST_IDLE;
      tgt_idx_r <= {`OTP_IDX_W{1'b0}};
      pdata_r <= `OTP_BLANK_WORD;
      perr_r <= 1'b0;
      lerr_r <= 1'b0;
      hit_d_r <= 1'b0;
      cmd_bad_r <= 1'b0;
   end
   else
   begin
      mode_r <= mode_nxt;
      state_r <= state_nxt;
      tgt_idx_r <= tgt_idx_nxt;
      pdata_r <= pdata_nxt;
      perr_r <= perr_nxt;
      lerr_r <= lerr_nxt;
      hit_d_r <= in_space;
      cmd_bad_r <= cmd_bad_nxt;
   end
end

// ==========================================================
// storage array
// factory number preloaded
otp_prot_mem #(
   .DW(16),
   .AW(`OTP_IDX_W),
   .DEPTH(DEPTH),
   .FACTORY_ID(FACTORY_ID)
) u_mem (
   .clock(clock),
   .raddr(mem_raddr),
   .rdata(mem_rdata),
   .we(mem_we),
   .waddr(tgt_idx_r),
   .wdata(mem_wdata)
);

// ==========================================================
// read data path
wire [7:0] status_byte;
reg [15:0] dq_out_r;

assign status_byte = {(state_r == ST_IDLE), 2'b00, perr_r, 2'b00, lerr_r, 1'b0};

always @(posedge clock or negedge rstn)
begin
   if (!rstn)
      dq_out_r <= 16'h0000;
   else if ((mode_r == MODE_ID) && (state_r == ST_IDLE))
      dq_out_r <= hit_d_r ? mem_rdata : 16'h0000;
   else if (mode_r == MODE_ARRAY)
      dq_out_r <= `OTP_BLANK_WORD;
   else
      dq_out_r <= {8'h00, status_byte};
end

// drive while selected and read strobe low
assign dq_out = dq_out_r;
assign dq_oe_n = ce_s_n | oe_s_n;

endmodule // otp_prot_regs

// ==== otp_consts.vh ====
// constants of the one-time-programmable protection register unit
// assumes word offsets on the flash bus and 16-bit data words
`ifndef OTP_CONSTS_VH
`define OTP_CONSTS_VH

// ==========================================================
// bus commands, low byte of the written word
`define OTP_CMD_READ_ID 8'h90
`define OTP_CMD_READ_ARRAY 8'hFF
`define OTP_CMD_READ_STATUS 8'h70
`define OTP_CMD_CLEAR_STATUS 8'h50
`define OTP_CMD_PROG_PROT 8'hC0

// ==========================================================
// identifier-space word offsets
`define OTP_OFS_W 9
`define OTP_LOCK_A_OFS 9'h080
`define OTP_LOCK_B_OFS 9'h089
`define OTP_SPACE_FIRST 9'h080
`define OTP_SPACE_LAST 9'h109

// ==========================================================
// storage indices, offset minus first offset of the space
`define OTP_IDX_W 8
`define OTP_IDX_LOCK_A 8'h00
`define OTP_IDX_LOCK_B 8'h09
`define OTP_IDX_FACT_LAST 8'h04
`define OTP_IDX_USER0_LAST 8'h08
`define OTP_IDX_BLK_FIRST 8'h0A
`define OTP_WORDS_PER_BLK_LOG2 3

// ==========================================================
// lock word fields and initial values
`define OTP_LOCK_A_FACT_BIT 0
`define OTP_LOCK_A_USER_BIT 1
`define OTP_LOCK_A_INIT 16'hFFFE
`define OTP_BLANK_WORD 16'hFFFF

// ==========================================================
// status byte fields
`define OTP_SR_READY_BIT 7
`define OTP_SR_PERR_BIT 4
`define OTP_SR_LERR_BIT 1

`endif

// ==== otp_prot_mem.v ====
// storage array for the protection words and the two lock words
// assumes one read and one write port on the same clock
`timescale 1ns/100ps
`include "otp_consts.vh"

module otp_prot_mem #(
   parameter DW = 16,
   parameter AW = 8,
   parameter DEPTH = 256,
   // factory device number, value arbitrary
   parameter [63:0] FACTORY_ID = 64'h0123456789ABCDEF
) (
   // clock
   input wire clock,
   // read port
   input wire [AW-1:0] raddr,
   output reg [DW-1:0] rdata,
   // write port
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [DW-1:0] wdata
);

reg [DW-1:0] mem [0:DEPTH-1];
integer i;

// contents as delivered: blank, factory number, factory lock bit
initial
begin
   for (i = 0; i < DEPTH; i = i + 1)
      mem[i] = `OTP_BLANK_WORD;
   for (i = 0; i < 4; i = i + 1)
      mem[i + 1] = FACTORY_ID[16*i +: 16];
   mem[`OTP_IDX_LOCK_A] = `OTP_LOCK_A_INIT;
end

// registered read, plain write
always @(posedge clock)
begin
   rdata <= mem[raddr];
   if (we)
      mem[waddr] <= wdata;
end

endmodule // otp_prot_mem

// ==== otp_host_model.sv ====
// host model driving the flash bus pins of the protection unit
// assumes one clock; pins change by nba just after a rising edge
`timescale 1ns/100ps

module otp_host_model (
   // clock
   input wire clock,
   // pins to the device
   output reg ce_n,
   output reg we_n,
   output reg oe_n,
   output reg [15:0] addr,
   output reg [15:0] dq_in,
   // answer from the device
   input wire [15:0] dq_out,
   input wire dq_oe_n
);
   // =====================================
   // idle pins at time zero
   initial
   begin
      ce_n = 1'b1;
      we_n = 1'b1;
      oe_n = 1'b1;
      addr = 16'h0000;
      dq_in = 16'h0000;
   end

   // wait some rising edges
   task tick(input integer n);
      repeat (n) @(posedge clock);
   endtask

   // command or data word, held around the strobe
   task wr(input [15:0] a, input [15:0] d);
      @(posedge clock);
      ce_n <= 1'b0;
      addr <= a;
      dq_in <= d;
      tick(3);
      we_n <= 1'b0;
      tick(3);
      we_n <= 1'b1;
      tick(3);
      ce_n <= 1'b1;
      addr <= ~a;
      dq_in <= ~d;
      tick(6);
   endtask

   // one word read, sampled once settled
   task rd(input [15:0] a, output [15:0] d, output oe);
      @(posedge clock);
      ce_n <= 1'b0;
      oe_n <= 1'b0;
      addr <= a;
      tick(6);
      d = dq_out;
      oe = dq_oe_n;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      addr <= ~a;
      tick(3);
   endtask
endmodule // otp_host_model

// ==== otp_prot_regs_asserts.sv ====
// checker on the pins of the protection unit
// assumes bind to otp_prot_regs, one clock
`timescale 1ns/100ps

module otp_prot_regs_asserts #(
   parameter ADDR_W = 16
) (
   // clock and reset
   input wire clock,
   input wire rstn,
   // flash bus pins
   input wire ce_n,
   input wire we_n,
   input wire oe_n,
   input wire [ADDR_W-1:0] addr,
   input wire [15:0] dq_in,
   input wire [15:0] dq_out,
   input wire dq_oe_n
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   // =====================================
   // both strobes low
   sequence s_drive;
      !ce_n && !oe_n;
   endsequence

   chk_oe_track: assert property (dq_oe_n == $past(ce_n | oe_n, 2))
      else $error("output enable off track");
   chk_oe_fall: assert property ($fell(dq_oe_n) |-> $past(!ce_n && !oe_n, 2))
      else $error("output enable fell unasked");
   chk_oe_rise: assert property ($rose(dq_oe_n) |-> $past(ce_n || oe_n, 2))
      else $error("output enable rose early");
   chk_drive_on: assert property (s_drive ##1 s_drive |=> !dq_oe_n)
      else $error("read not driven");
   chk_idle_off: assert property ((ce_n || oe_n) [*3] |-> dq_oe_n)
      else $error("driving while idle");
   chk_sel_end: assert property ($rose(ce_n) |-> ##2 dq_oe_n)
      else $error("drive after deselect");
   chk_read_end: assert property ($rose(oe_n) |-> ##2 dq_oe_n)
      else $error("drive after read end");
   chk_drive_span: assert property (s_drive ##1 s_drive ##1 ce_n |=> !dq_oe_n ##1 dq_oe_n)
      else $error("read span wrong");
endmodule // otp_prot_regs_asserts

bind otp_prot_regs otp_prot_regs_asserts #(.ADDR_W(ADDR_W)) chk_inst (.clock(clock),
   .rstn(rstn), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_in(dq_in),
   .dq_out(dq_out), .dq_oe_n(dq_oe_n));

// ==== testbench.sv ====
// self-checking bench for the protection register unit
// assumes otp_host_model drives the pins
`timescale 1ns/100ps
`include "otp_consts.vh"

module testbench;
   reg clock;
   reg rstn;
   wire ce_n;
   wire we_n;
   wire oe_n;
   wire dq_oe_n;
   wire [15:0] addr;
   wire [15:0] dq_in;
   wire [15:0] dq_out;
   integer n_mismatch;
   integer n_checks;
   integer i;
   reg [15:0] rdata;
   reg roe;
   // factory number, value arbitrary
   localparam [63:0] FID = 64'h5A3C96E10F27B48D;
   localparam [15:0] HI = 16'hFE00;

   // =====================================
   // host model and device
   otp_host_model otp_host_model_inst (.clock(clock), .ce_n(ce_n), .we_n(we_n),
      .oe_n(oe_n), .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n));
   otp_prot_regs #(.FACTORY_ID(FID)) otp_prot_regs_inst (.clock(clock), .rstn(rstn),
      .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe_n(dq_oe_n));

   // 25 ns clock
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // =====================================
   // compare and count
   task chk(input [15:0] got, input [15:0] exp);
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // identifier read at some address, then word read
   task idrd(input [15:0] a, input [15:0] exp);
      otp_host_model_inst.wr(16'h0123, {8'h00, `OTP_CMD_READ_ID});
      otp_host_model_inst.rd(a, rdata, roe);
      chk({15'h0000, roe}, 16'h0000);
      chk(rdata, exp);
   endtask

   // program with upper address bits high
   task prog(input [15:0] a, input [15:0] d);
      otp_host_model_inst.wr(HI | a, {8'h00, `OTP_CMD_PROG_PROT});
      otp_host_model_inst.wr(HI | a, d);
   endtask

   // status word, then clear it
   task stat(input [15:0] exp);
      otp_host_model_inst.rd(16'h0000, rdata, roe);
      chk(rdata, exp);
      otp_host_model_inst.wr(16'h0000, {8'h00, `OTP_CMD_CLEAR_STATUS});
   endtask

   // =====================================
   // delivered contents
   task t_factory;
      idrd(16'h0080, 16'hFFFE);
      for (i = 0; i < 4; i = i + 1)
         idrd(16'h0081 + i, FID[16*i +: 16]);
      idrd(16'h0085, 16'hFFFF);
      idrd(16'h0109, 16'hFFFF);
   endtask

   // word programming and one-way bits
   task t_prog;
      prog(16'h008D, 16'h1234);
      stat(16'h0080);
      idrd(16'h008D, 16'h1234);
      prog(16'h008D, 16'hFF0F);
      stat(16'h0080);
      idrd(16'h008D, 16'h1204);
      prog(16'h0010, 16'h0000);
      stat(16'h0090);
      // command outside the space, data word aimed inside it
      otp_host_model_inst.wr(HI | 16'h0010, {8'h00, `OTP_CMD_PROG_PROT});
      otp_host_model_inst.wr(HI | 16'h0093, 16'h0000);
      stat(16'h0090);
      idrd(16'h0093, 16'hFFFF);
   endtask

   // locking and refusals
   task t_lock;
      prog(16'h0080, 16'hFFFD);
      stat(16'h0080);
      idrd(16'h0080, 16'hFFFC);
      prog(16'h0085, 16'h0000);
      stat(16'h0092);
      idrd(16'h0085, 16'hFFFF);
      prog(16'h0081, 16'h0000);
      stat(16'h0092);
      prog(16'h0089, 16'hFFFE);
      stat(16'h0080);
      prog(16'h008D, 16'h0000);
      stat(16'h0092);
      idrd(16'h008D, 16'h1204);
      prog(16'h0092, 16'h00FF);
      stat(16'h0080);
      idrd(16'h0092, 16'h00FF);
      prog(16'h0080, 16'hFFFF);
      stat(16'h0080);
      idrd(16'h0080, 16'hFFFC);
   endtask

   // array and status read modes, then a reset in mid-run
   task t_modes;
      otp_host_model_inst.wr(16'h0000, {8'h00, `OTP_CMD_READ_ARRAY});
      otp_host_model_inst.rd(16'h008D, rdata, roe);
      chk(rdata, `OTP_BLANK_WORD);
      prog(16'h0010, 16'h0000);
      otp_host_model_inst.wr(16'h0000, {8'h00, `OTP_CMD_READ_ARRAY});
      otp_host_model_inst.wr(16'h0000, {8'h00, `OTP_CMD_READ_STATUS});
      otp_host_model_inst.rd(16'h0000, rdata, roe);
      chk(rdata, 16'h0090);
      // reset with an error pending, pins idle
      @(posedge clock);
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      chk(dq_out, 16'h0000);
      chk({15'h0000, dq_oe_n}, 16'h0001);
      rstn <= 1'b1;
      otp_host_model_inst.rd(16'h008D, rdata, roe);
      chk(rdata, `OTP_BLANK_WORD);
      otp_host_model_inst.wr(16'h0000, {8'h00, `OTP_CMD_READ_STATUS});
      stat(16'h0080);
      idrd(16'h008D, 16'h1204);
   endtask

   // verdict and end of run
   task stop_test;
      if (n_mismatch == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // =====================================
   // main sequence
   initial
   begin
      n_mismatch = 0;
      n_checks = 0;
      rstn = 1'b0;
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      t_factory;
      t_prog;
      t_lock;
      t_modes;
      stop_test;
   end

   // watchdog on a hang
   initial
   begin
      #400000;
      n_mismatch = n_mismatch + 1;
      stop_test;
   end
endmodule // testbench
